// *** src/ctx_sched_pkg.sv ***
// context submission scheduler: shared constants and types
// assumes one engine per scheduler instance, 10 MHz mclk
package ctx_sched_pkg;

	// register indices on the plain register port
	localparam logic [3:0] ADDR_MODE     = 4'h0; // mode register
	localparam logic [3:0] ADDR_SUBMIT_LO = 4'h1; // descriptor bits 31:0
	localparam logic [3:0] ADDR_SUBMIT_HI = 4'h2; // descriptor 63:32, submits
	localparam logic [3:0] ADDR_STATUS   = 4'h3; // engine state
	localparam logic [3:0] ADDR_CUR_LO   = 4'h4; // running descriptor low
	localparam logic [3:0] ADDR_CUR_HI   = 4'h5; // running descriptor high
	localparam logic [3:0] ADDR_EVENT    = 4'h6; // wait / fault / resume
	localparam logic [3:0] ADDR_ENGINE   = 4'h7; // own engine identifier

	// mode register fields
	localparam int MODE_EXECLIST_BIT = 0;
	localparam int MODE_RESTORE_INHIBIT_BIT = 1; // render: skip engine state
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;

	// descriptor fields
	localparam int DESC_VALID_BIT = 0;
	localparam int DESC_GLOBAL_BIT = 3;          // address space selection
	localparam int DESC_PROXY_BIT = 20;
	localparam int DESC_ADDR_LSB = 12;           // image address, 4 KiB aligned
	localparam int DESC_ENGID_LSB = 61;
	localparam int DESC_ENGID_W = 3;

	// image layout: status page then ring context then engine context
	localparam logic [31:0] STATUS_PAGE_BYTES = 32'h0000_1000;
	localparam logic [31:0] RING_CTX_BYTES = 32'h0000_0140; // five lines

	// event register fields
	localparam int EVT_WAIT_BIT = 0;
	localparam int EVT_FAULT_BIT = 1;
	localparam int EVT_RESUME_BIT = 2;
	localparam int EVT_DONE_BIT = 3;
	localparam int EVT_ENGID_LSB = 8;

	// execution list depth
	localparam int QUEUE_DEPTH = 4;
	localparam int QUEUE_AW = 2;

	typedef enum logic [5:0] {
		ST_IDLE    = 6'b000001,
		ST_RESTORE = 6'b000010,
		ST_RUN     = 6'b000100,
		ST_WAIT    = 6'b001000,
		ST_SAVE    = 6'b010000,
		ST_FAULT   = 6'b100000
	} engine_state_t;

	typedef enum logic [1:0] {
		MEM_NONE    = 2'h0,
		MEM_RESTORE = 2'h1,
		MEM_SAVE    = 2'h2
	} mem_op_t;

endpackage

// *** src/image_address_gen.sv ***
// image address generator for one context save or restore
// assumes the memory side acknowledges each phase with memDone
`timescale 1ns/1ps
module image_address_gen
	import ctx_sched_pkg::*;
(
	// clock and control
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	// request from the scheduler
	input  wire logic        start,
	input  wire logic [31:0] imageBase,
	input  wire logic        skipEngine,
	// memory handshake
	input  wire logic        memDone,
	output logic             phaseEngine,
	output logic [31:0]      phaseAddr,
	output logic             busy,
	output logic             finished
);

	logic        busy_r;
	logic        busy_nxt;
	logic        eng_r;
	logic        eng_nxt;
	logic [31:0] ringAddr;
	logic [31:0] engAddr;
	logic        lastPhase;

	////////////////////////////////////////////////////////////////////
	// ring context follows the status page; engine state follows it
	assign ringAddr = imageBase + STATUS_PAGE_BYTES;
	assign engAddr = ringAddr + RING_CTX_BYTES;
	assign lastPhase = eng_r | skipEngine;
	assign busy_nxt = start ? 1'b1 : ((memDone && lastPhase) ? 1'b0 : busy_r);
	assign eng_nxt = start ? 1'b0 : ((memDone && !lastPhase) ? 1'b1 : eng_r);
	assign phaseEngine = eng_r;
	assign phaseAddr = eng_r ? engAddr : ringAddr;
	assign busy = busy_r;
	assign finished = busy_r & memDone & lastPhase;

	// phase register, ring context always first
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
			eng_r <= 1'b0;
		end else if (clkEn) begin
			busy_r <= busy_nxt;
			eng_r <= eng_nxt;
		end
	end

endmodule // image_address_gen

// *** src/context_submission_scheduler.sv ***
// context submission scheduler for one engine: submit port,
// execution list that rotates blocked direct contexts, context save and restore sequencing
// assumes software on a plain register port and memory that acks
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps

module context_submission_scheduler
	import ctx_sched_pkg::*;
#(
	parameter logic [DESC_ENGID_W-1:0] ENGINE_ID = 3'h0 // arbitrary
)(
	// clock and control
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdData,
	// memory side of save and restore
	output logic             memReq,
	output logic             memWrite,
	output logic             memGlobal,
	output logic [31:0]      memAddr,
	input  wire logic        memDone,
	// engine status
	output logic             engineBusy,
	output logic             proxyMismatch
);

	////////////////////////////////////////////////////////////////////
	// storage
	logic [31:0]         mode_r;
	logic [31:0]         stageLo_r;
	logic [63:0]         queue_r [QUEUE_DEPTH];
	logic [QUEUE_AW-1:0] head_r;
	logic [QUEUE_AW-1:0] tail_r;
	logic [QUEUE_AW:0]   count_r;
	engine_state_t       state_r;
	engine_state_t       state_nxt;
	logic [31:0]         rdData_r;
	logic                mismatch_r;
	logic                evtMatch_r;

	// decode of register writes
	logic        wrMode;
	logic        wrLo;
	logic        wrHi;
	logic        wrEvent;
	logic [63:0] newDesc;
	logic        descValid;
	logic        descProxy;
	logic        proxyOk;
	logic        queueFull;
	logic        accept;
	logic        evtForUs;
	logic        evtWait;
	logic        evtFault;
	logic        evtResume;
	logic        evtDone;
	logic [63:0] headDesc;
	logic        headProxy;
	logic        pop;
	logic        genStart;
	logic        genBusy;
	logic        genDone;
	logic [31:0] genAddr;
	logic [31:0] rdMux;

	assign wrMode = regWr && (regAddr == ADDR_MODE);
	assign wrLo = regWr && (regAddr == ADDR_SUBMIT_LO);
	assign wrHi = regWr && (regAddr == ADDR_SUBMIT_HI);
	assign wrEvent = regWr && (regAddr == ADDR_EVENT);
	// the high word is the submitting write; the low word only stages
	assign newDesc = {regWrData, stageLo_r};

	////////////////////////////////////////////////////////////////////
	// descriptor decode: identifier, proxy, address, valid
	assign descValid = newDesc[DESC_VALID_BIT];
	assign descProxy = newDesc[DESC_PROXY_BIT];
	// proxy: identifier 19:0 must mirror image address 31:20
	assign proxyOk = !descProxy || (newDesc[51:32] == {8'h00, newDesc[31:20]});
	// a full list drops the submit silently: software keeps its own
	// count of outstanding contexts, there is no back-pressure
	assign queueFull = (count_r == (QUEUE_AW + 1)'(QUEUE_DEPTH));
	// list refused when disabled; invalid descriptor starts nothing
	assign accept = wrHi && mode_r[MODE_EXECLIST_BIT] && descValid
		&& !queueFull;

	// wait, fault and resume events carry an engine identifier
	// events for another engine are dropped, reported as unmatched
	assign evtForUs = wrEvent &&
		(regWrData[EVT_ENGID_LSB +: DESC_ENGID_W] == ENGINE_ID);
	assign evtWait = evtForUs && regWrData[EVT_WAIT_BIT];
	assign evtFault = evtForUs && regWrData[EVT_FAULT_BIT];
	assign evtResume = evtForUs && regWrData[EVT_RESUME_BIT];
	assign evtDone = evtForUs && regWrData[EVT_DONE_BIT];

	// the running or next context is always the list head
	assign headDesc = queue_r[head_r];
	assign headProxy = headDesc[DESC_PROXY_BIT];

	////////////////////////////////////////////////////////////////////
	// engine state machine
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				// no reordering: the head always goes first
				if (count_r != '0)
					state_nxt = ST_RESTORE;
			end
			ST_RESTORE: begin
				// engine phase skipped while restore is inhibited
				if (genDone)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				// fault wins over wait when both arrive together
				if (evtFault)
					state_nxt = ST_FAULT;
				else if (evtWait)
					state_nxt = ST_WAIT;
				else if (evtDone)
					state_nxt = ST_SAVE;
			end
			ST_WAIT: begin
				// proxy holds its place; direct is switched out
				if (!headProxy)
					state_nxt = ST_SAVE;
				else if (evtResume)
					state_nxt = ST_RUN;
			end
			ST_FAULT: begin
				// no other context runs while proxy head faults
				if (!headProxy)
					state_nxt = ST_SAVE;
				else if (evtResume)
					state_nxt = ST_RUN;
			end
			ST_SAVE: begin
				// a save always writes both phases back
				if (genDone)
					state_nxt = ST_IDLE;
			end
		endcase
	end

	// a direct context blocked by wait or fault is rotated to the tail
	// so other contexts proceed; completed contexts leave the list
	logic requeue;
	logic requeue_r;
	assign requeue = requeue_r;
	assign pop = (state_r == ST_SAVE) && genDone;
	// a restore starts from idle with a list entry; a save when a run ends or a direct head blocks
	assign genStart = ((state_r == ST_IDLE) && (count_r != '0)) ||
		(((state_r == ST_RUN) && evtDone) ||
		(((state_r == ST_WAIT) || (state_r == ST_FAULT)) && !headProxy));

	// restore and save walk the same image phases; a restore skips the engine phase while restore is inhibited
	image_address_gen u_addr (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.clkEn       (clkEn),
		.start       (genStart),
		.imageBase   ({headDesc[31:DESC_ADDR_LSB], 12'h000}),
		.skipEngine  (mode_r[MODE_RESTORE_INHIBIT_BIT] && !memWrite),
		.memDone     (memDone),
		.phaseEngine (),
		.phaseAddr   (genAddr),
		.busy        (genBusy),
		.finished    (genDone)
	);

	////////////////////////////////////////////////////////////////////
	// memory request: save writes, restore reads, same image address
	assign memReq = genBusy;
	assign memWrite = (state_r == ST_SAVE);
	// no per-process space for images, whatever the descriptor asks
	assign memGlobal = 1'b1;
	assign memAddr = genAddr;

	// read mux
	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (regAddr)
			ADDR_MODE: rdMux = mode_r;
			ADDR_SUBMIT_LO: rdMux = stageLo_r;
			// status: state, event matched, proxy mismatch, list count
			ADDR_STATUS: rdMux = {21'h00_0000, count_r, mismatch_r,
				evtMatch_r, state_r};
			ADDR_CUR_LO: rdMux = headDesc[31:0];
			ADDR_CUR_HI: rdMux = headDesc[63:32];
			ADDR_ENGINE: rdMux = {29'h0, ENGINE_ID};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// per-engine execution list, flip-flop storage
	// a blocked direct head is copied to the tail as it leaves the
	// head, so it runs again after the others; a new descriptor taken
	// in that same cycle lands one slot behind it
	logic                rotate;
	logic                grow;
	logic                shrink;
	logic [QUEUE_AW-1:0] newSlot;
	logic [QUEUE_AW-1:0] tailStep;
	assign rotate = pop && requeue;
	assign grow = accept && !(pop && !requeue);
	assign shrink = !accept && pop && !requeue;
	assign newSlot = rotate ? (tail_r + 1'b1) : tail_r;
	assign tailStep = {1'b0, accept} + {1'b0, rotate};

	// one write port per slot; the two hits never share a slot
	genvar gi;
	generate
		for (gi = 0; gi < QUEUE_DEPTH; gi++) begin : g_entry
			logic hitNew;
			logic hitRot;
			assign hitNew = accept && (newSlot == QUEUE_AW'(gi));
			assign hitRot = rotate && (tail_r == QUEUE_AW'(gi));
			always_ff @(posedge mclk) begin
				if (sys_rst)
					queue_r[gi] <= 64'h0;
				else if (clkEn && hitNew)
					queue_r[gi] <= newDesc;
				else if (clkEn && hitRot)
					queue_r[gi] <= headDesc;
			end
		end
	endgenerate

	// list pointers: rotate on blocked direct context, drop on done
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			head_r <= '0;
			tail_r <= '0;
			count_r <= '0;
			requeue_r <= 1'b0;
		end else if (clkEn) begin
			tail_r <= tail_r + tailStep;
			if (pop)
				head_r <= head_r + 1'b1;
			if (grow)
				count_r <= count_r + 1'b1;
			else if (shrink)
				count_r <= count_r - 1'b1;
			if (genStart)
				requeue_r <= (state_r == ST_WAIT) || (state_r == ST_FAULT);
		end
	end

	// state and software registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			mode_r <= MODE_RESET;
			stageLo_r <= 32'h0;
			rdData_r <= 32'h0;
			mismatch_r <= 1'b0;
			evtMatch_r <= 1'b0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			if (wrMode)
				mode_r <= regWrData;
			if (wrLo)
				stageLo_r <= regWrData;
			if (regRd)
				rdData_r <= rdMux;
			if (wrHi && descValid)
				mismatch_r <= !proxyOk;
			if (wrEvent)
				evtMatch_r <= evtForUs;
		end
	end

	// outputs straight from state and flags
	assign regRdData = rdData_r;
	assign engineBusy = (state_r != ST_IDLE);
	assign proxyMismatch = mismatch_r;

endmodule // context_submission_scheduler

// *** testbench/ctx_sched_sva.sv ***
// checker: submit acceptance and image save/restore order
// assumes it is bound onto the scheduler, one mclk domain
`timescale 1ns/1ps
module ctx_sched_sva
	import ctx_sched_pkg::*;
#(
	parameter logic [DESC_ENGID_W-1:0] ENGINE_ID = 3'h0
)(
	// clock and control
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        clkEn,
	// register port
	input wire logic [3:0]  regAddr,
	input wire logic [31:0] regWrData,
	input wire logic        regWr,
	// memory side and status
	input wire logic        memReq,
	input wire logic        memWrite,
	input wire logic        memGlobal,
	input wire logic [31:0] memAddr,
	input wire logic        memDone,
	input wire logic        engineBusy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
////////////////////////////////
	// shadow state; a save must reuse the last restored image
	logic        modeEn_r;
	logic        loValid_r;
	logic        reqPrev_r;
	logic [31:0] restAddr_r;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			modeEn_r   <= 1'b0;
			loValid_r  <= 1'b0;
			reqPrev_r  <= 1'b0;
			restAddr_r <= 32'h0;
		end else begin
			reqPrev_r <= memReq;
			if (clkEn && regWr && regAddr == ADDR_MODE)
				modeEn_r <= regWrData[MODE_EXECLIST_BIT];
			if (clkEn && regWr && regAddr == ADDR_SUBMIT_LO)
				loValid_r <= regWrData[DESC_VALID_BIT];
			if (memReq && !reqPrev_r && !memWrite)
				restAddr_r <= memAddr;
		end
	end
////////////////////////////////
	sequence hiWrite;
		clkEn && regWr && regAddr == ADDR_SUBMIT_HI;
	endsequence
	sequence restoreStart;
		engineBusy && memReq && !memWrite;
	endsequence
	global_space_a: assert property (memReq |-> memGlobal)
		else $error("image access not global");
	idle_quiet_a: assert property (!engineBusy |-> !memReq)
		else $error("memory access while idle");
	addr_hold_a: assert property (
		memReq && !(memDone && clkEn) |=> memReq && $stable(memAddr))
		else $error("phase address dropped early");
	ring_first_a: assert property (
		$rose(memReq) |-> memAddr[11:0] == 12'h000)
		else $error("ring context not first");
	engine_next_a: assert property (
		memReq && memDone && clkEn && memWrite && memAddr[11:0] == 12'h000
		|=> memReq && memWrite && memAddr == $past(memAddr) + RING_CTX_BYTES)
		else $error("engine save not after ring");
	submit_start_a: assert property (
		hiWrite ##0 (modeEn_r && loValid_r && !engineBusy)
		|-> ##[1:2] restoreStart) else $error("submit not started");
	drop_refused_a: assert property (
		hiWrite ##0 (!engineBusy && !(modeEn_r && loValid_r))
		|=> !engineBusy [*2]) else $error("refused submit started");
	save_same_a: assert property (
		$rose(memReq) && memWrite |-> memAddr == restAddr_r)
		else $error("save address differs");
endmodule // ctx_sched_sva

bind context_submission_scheduler ctx_sched_sva #(.ENGINE_ID(ENGINE_ID))
	i_chk (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.memReq(memReq), .memWrite(memWrite), .memGlobal(memGlobal),
	.memAddr(memAddr), .memDone(memDone), .engineBusy(engineBusy));

// *** testbench/mem_image_model.sv ***
// memory holding context images: acks each save/restore phase
// assumes lat is held steady while a phase is outstanding
`timescale 1ns/1ps
module mem_image_model (
	// clock and reset
	input wire logic       mclk,
	input wire logic       sys_rst,
	// scheduler side
	input wire logic       memReq,
	input wire logic [3:0] lat,
	output logic           memDone
);
	// one-cycle ack after lat waits, so prompt and slow both occur
	logic [3:0] count_r;
	always_ff @(posedge mclk) begin
		if (sys_rst || !memReq || memDone) begin
			memDone <= 1'b0;
			count_r <= 4'h0;
		end else begin
			memDone <= (count_r == lat);
			count_r <= count_r + 4'h1;
		end
	end
endmodule // mem_image_model

// *** testbench/testbench.sv ***
// testbench for the context scheduler with a memory model
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
module testbench
	import ctx_sched_pkg::*;
;
	localparam logic [2:0]  ENG = 3'h2;
	// images and their translation stand ready before a first submit
	localparam logic [31:0] IMG_A = 32'h0023_4000;
	localparam logic [31:0] IMG_B = 32'h0045_6000;
	localparam logic [31:0] IMG_P = 32'h0031_2000;
	localparam logic [31:0] IMG_Q = 32'h0057_8000;
	localparam logic [31:0] RING = STATUS_PAGE_BYTES;
	localparam logic [31:0] ENGC = STATUS_PAGE_BYTES + RING_CTX_BYTES;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clkEn = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [3:0]  memLat = 4'h0;
	logic [7:0]  subCnt = 8'h0;
	logic        proxyMismatch;
	logic [31:0] regRdData;
	logic [31:0] memAddr;
	logic        memReq;
	logic        memWrite;
	logic        memGlobal;
	logic        memDone;
	logic        engineBusy;
	int          num_errors = 0;
	int          total_checks = 0;
	always #50 mclk = ~mclk;
////////////////////////////////
	context_submission_scheduler #(.ENGINE_ID(ENG)) i_dut (.mclk(mclk),
		.sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .memReq(memReq), .memWrite(memWrite),
		.memGlobal(memGlobal), .memAddr(memAddr), .memDone(memDone),
		.engineBusy(engineBusy), .proxyMismatch(proxyMismatch));
	mem_image_model i_mem (.mclk(mclk), .sys_rst(sys_rst),
		.memReq(memReq), .lat(memLat), .memDone(memDone));
////////////////////////////////
	task conclude;
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	function logic [31:0] ev(input int b, input logic [2:0] id);
		return (32'h1 << b) | {21'h0, id, 8'h0};
	endfunction
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		d = regRdData;
	endtask
	// low word carries address, space, proxy and valid; the high word
	// carries engine, a fresh counter and, for proxy, the address bits
	task submit(input logic [31:0] img, input logic px, input logic vld);
		wr(ADDR_SUBMIT_LO, {img[31:12], 12'h008} | {11'h0, px, 19'h0, vld});
		wr(ADDR_SUBMIT_HI, {ENG, subCnt, 1'b0,
			(px ? {8'h00, img[31:20]} : 20'h0)});
		subCnt++;
	endtask
	// bounded wait for the next memory handshake, then judge it
	task phase(input logic [31:0] a, input logic w);
		int i;
		i = 0;
		do begin @(negedge mclk); i++; end
		while (!(memReq === 1'b1 && memDone === 1'b1) && i < 300);
		check("memAddr", a, memAddr);
		check("memWrite", {31'h0, w}, {31'h0, memWrite});
		check("memGlobal", 32'h1, {31'h0, memGlobal});
		if (i >= 300) begin
			check("phaseLimit", 32'h0, 32'h1);
			conclude;
		end
	endtask
	task waitState(input logic b);
		int i;
		i = 0;
		do begin @(negedge mclk); i++; end
		while (!(engineBusy === b && memReq === 1'b0) && i < 300);
		check("engineBusy", {31'h0, b}, {31'h0, engineBusy});
		if (i >= 300) begin
			check("busyLimit", 32'h0, 32'h1);
			conclude;
		end
	endtask
	task quiet(input int n, input logic b);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge mclk);
			if (memReq !== 1'b0 || engineBusy !== b) seen = 1'b1;
		end
		check("quiet", 32'h0, {31'h0, seen});
	endtask
	task resetDut(input logic [3:0] lat);
		@(posedge mclk);
		sys_rst <= 1'b1;
		memLat <= lat;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
	endtask
////////////////////////////////
	task t_refused;
		logic [31:0] d;
		resetDut(4'h0);
		rd(ADDR_MODE, d);
		check("modeReset", MODE_RESET, d);
		rd(4'hf, d);
		check("unmapped", 32'h0, d);
		submit(IMG_A, 1'b0, 1'b1);
		quiet(8, 1'b0);
		wr(ADDR_MODE, 32'h1);
		submit(IMG_A, 1'b0, 1'b0);
		quiet(8, 1'b0);
		wr(ADDR_SUBMIT_LO, IMG_P | 32'h0000_0009);
		wr(ADDR_SUBMIT_HI, {ENG, 29'h1});
		@(negedge mclk);
		check("proxyBad", 32'h1, {31'h0, proxyMismatch});
		submit(IMG_P, 1'b1, 1'b1);
		@(negedge mclk);
		check("proxyGood", 32'h0, {31'h0, proxyMismatch});
	endtask
	task t_direct;
		logic [31:0] d;
		resetDut(4'h3);
		wr(ADDR_MODE, 32'h1);
		submit(IMG_A, 1'b0, 1'b1);
		phase(IMG_A + RING, 1'b0);
		phase(IMG_A + ENGC, 1'b0);
		waitState(1'b1);
		rd(ADDR_CUR_LO, d);
		check("curLo", {IMG_A[31:12], 12'h009}, d);
		rd(ADDR_STATUS, d);
		check("status", {21'h0, 3'h1, 2'h0, ST_RUN}, d);
		rd(ADDR_ENGINE, d);
		check("engineId", {29'h0, ENG}, d);
		submit(IMG_B, 1'b0, 1'b1);
		wr(ADDR_EVENT, ev(EVT_WAIT_BIT, ENG + 3'h1));
		quiet(10, 1'b1);
		wr(ADDR_EVENT, ev(EVT_WAIT_BIT, ENG));
		phase(IMG_A + RING, 1'b1);
		phase(IMG_A + ENGC, 1'b1);
		phase(IMG_B + RING, 1'b0);
		phase(IMG_B + ENGC, 1'b0);
		waitState(1'b1);
		wr(ADDR_EVENT, ev(EVT_DONE_BIT, ENG));
		phase(IMG_B + RING, 1'b1);
		phase(IMG_B + ENGC, 1'b1);
		phase(IMG_A + RING, 1'b0);
	endtask
	task t_proxy;
		resetDut(4'h0);
		wr(ADDR_MODE, 32'h1);
		submit(IMG_P, 1'b1, 1'b1);
		phase(IMG_P + RING, 1'b0);
		phase(IMG_P + ENGC, 1'b0);
		waitState(1'b1);
		submit(IMG_Q, 1'b1, 1'b1);
		wr(ADDR_EVENT, ev(EVT_FAULT_BIT, ENG));
		quiet(10, 1'b1);
		wr(ADDR_EVENT, ev(EVT_RESUME_BIT, ENG));
		wr(ADDR_EVENT, ev(EVT_WAIT_BIT, ENG));
		quiet(10, 1'b1);
		wr(ADDR_EVENT, ev(EVT_RESUME_BIT, ENG));
		wr(ADDR_EVENT, ev(EVT_DONE_BIT, ENG));
		phase(IMG_P + RING, 1'b1);
		phase(IMG_P + ENGC, 1'b1);
		phase(IMG_Q + RING, 1'b0);
	endtask
	task t_inhibit;
		resetDut(4'h1);
		wr(ADDR_MODE, 32'h3);
		submit(IMG_A, 1'b0, 1'b1);
		phase(IMG_A + RING, 1'b0);
		quiet(4, 1'b1);
		@(posedge mclk);
		clkEn <= 1'b0;
		wr(ADDR_EVENT, ev(EVT_DONE_BIT, ENG));
		quiet(6, 1'b1);
		@(posedge mclk);
		clkEn <= 1'b1;
		wr(ADDR_EVENT, ev(EVT_DONE_BIT, ENG));
		phase(IMG_A + RING, 1'b1);
		phase(IMG_A + ENGC, 1'b1);
		waitState(1'b0);
	endtask
////////////////////////////////
	initial begin
		t_refused;
		t_direct;
		t_proxy;
		t_inhibit;
		conclude;
	end
	// overall limit in case a handshake never arrives
	initial begin
		repeat (100000) @(posedge mclk);
		check("runLimit", 32'h0, 32'h1);
		conclude;
	end
endmodule // testbench
